// >>> logic/upv_pkg.sv
// Contract
// - Vendor registers live at 30h through 3Fh
// - Register 31h bits 6:5 set amplitude boost
// - Headset audio only when 33h[3:0] is 1010
// - Conversion register: 36h load, 37h set, 38h clear
// - Bits 2:0 report converted ID resistance code
// - Done bit 3 sets after 282 us conversion
// - Conversion-register read clears done; carkit read not
// - Start bit 4 launches conversion, self-clears
// - Done rising with enable pulses alt_int
// - Interrupt enable is bit 6 OR carkit enable
// - I/O register: 39h load, 3Ah set, 3Bh clear
// - Swap bit 1 exchanges data lines, also serial
// - Serial mode with transmit enable uses bits 3:2
// - Bits 4/5 enable pull-ups; forced in serial mode
// - Other modes use regulator select bits 7:6
// - Event latch on done rise with enable, cleared when read
package upv_pkg;

    // ---------------------------------------------
    // Register addresses
    // ---------------------------------------------
    localparam logic [5:0] ADDR_VENDOR_LO = 6'h30;
    localparam logic [5:0] ADDR_VENDOR_HI = 6'h3F;
    localparam logic [5:0] ADDR_TX_AMP = 6'h31;
    localparam logic [5:0] ADDR_HEADSET = 6'h33;
    localparam logic [5:0] ADDR_RID_WR = 6'h36;
    localparam logic [5:0] ADDR_RID_SET = 6'h37;
    localparam logic [5:0] ADDR_RID_CLR = 6'h38;
    localparam logic [5:0] ADDR_IO_WR = 6'h39;
    localparam logic [5:0] ADDR_IO_SET = 6'h3A;
    localparam logic [5:0] ADDR_IO_CLR = 6'h3B;

    // ---------------------------------------------
    // Field positions, masks and reset values
    // ---------------------------------------------
    localparam int TX_AMP_LSB = 5;
    localparam logic [7:0] TX_AMP_MASK = 8'h60;
    localparam logic [7:0] HEADSET_MASK = 8'h0F;
    localparam logic [3:0] HEADSET_ENABLE_CODE = 4'hA;
    localparam int RID_VALUE_LSB = 0;
    localparam int RID_DONE_BIT = 3;
    localparam int RID_START_BIT = 4;
    localparam int RID_KEEP_ZERO_BIT = 5;
    localparam int RID_IRQ_EN_BIT = 6;
    localparam logic [7:0] RID_MASK = 8'h7F;
    localparam logic [7:0] RID_WRITE_MASK = 8'h77;
    localparam int IO_SWAP_BIT = 1;
    localparam int IO_SERIAL_REG_LSB = 2;
    localparam int IO_PULLUP_POS_BIT = 4;
    localparam int IO_PULLUP_NEG_BIT = 5;
    localparam int IO_USB_REG_LSB = 6;
    localparam logic [7:0] IO_MASK = 8'hFE;
    localparam logic [7:0] TX_AMP_RESET = 8'h00;
    localparam logic [7:0] HEADSET_RESET = 8'h00;
    localparam logic [7:0] RID_RESET = 8'h00;
    localparam logic [7:0] IO_RESET = 8'h04;

    // ---------------------------------------------
    // Timing
    // ---------------------------------------------
    localparam int CLK_MHZ = 250;
    localparam int CONV_TIME_US = 282;
    localparam int CONV_CYCLES = CONV_TIME_US * CLK_MHZ;

    // ---------------------------------------------
    // Types
    // ---------------------------------------------
    typedef enum logic [1:0] {
        WR_LOAD = 2'b00,
        WR_SET = 2'b01,
        WR_CLEAR = 2'b10
    } upv_wr_kind_type;

    typedef enum logic [0:0] {
        CONV_IDLE = 1'b0,
        CONV_BUSY = 1'b1
    } upv_conv_state_type;

    typedef struct packed {
        logic [1:0] tx_amplitude;
        logic headset_audio_enable;
        logic data_line_swap;
        logic charger_pullup_positive_line;
        logic charger_pullup_negative_line;
        logic [1:0] regulator_select;
    } upv_phy_ctrl_type;

    typedef struct packed {
        logic [2:0] id_resistance_code;
        logic id_conversion_done;
        logic id_conversion_event_latch;
    } upv_carkit_view_type;

endpackage : upv_pkg

// >>> logic/upv_vendor_regs.sv
`timescale 1ns/1ps
module upv_vendor_regs #(
    parameter int P_CONV_CYCLES = upv_pkg::CONV_CYCLES
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    // Register access port from the ULPI engine
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [5:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    output logic o_reg_hit,
    // Carkit side
    input wire logic i_carkit_irq_enable,
    input wire logic i_carkit_status_rd,
    input wire logic i_carkit_latch_rd,
    output upv_pkg::upv_carkit_view_type o_carkit_view,
    // Analog converter and mode
    input wire logic [2:0] i_id_adc_code,
    input wire logic i_serial_mode,
    input wire logic i_serial_transmit_enable,
    output logic o_id_conversion_active,
    // PHY controls and receive-command interrupt
    output upv_pkg::upv_phy_ctrl_type o_phy_ctrl,
    output logic o_alt_int
);
    import upv_pkg::*;

    localparam int CW = $clog2(P_CONV_CYCLES + 1);
    localparam logic [CW-1:0] CONV_LAST = CW'(P_CONV_CYCLES - 1);

    // ---------------------------------------------
    // Helpers
    // ---------------------------------------------
    // Load, set or clear one register
    function automatic logic [7:0] apply_wr(input logic [7:0] old, input logic [7:0] d,
                                            input upv_wr_kind_type k, input logic [7:0] m);
        logic [7:0] v;
        v = old;
        case (k)
            WR_LOAD: v = d;
            WR_SET: v = old | d;
            WR_CLEAR: v = old & ~d;
            default: v = old;
        endcase
        return v & m;
    endfunction : apply_wr

    // Decode triple-address access kind
    function automatic upv_wr_kind_type wr_kind(input logic [5:0] a, input logic [5:0] base);
        upv_wr_kind_type k;
        k = WR_LOAD;
        if (a == base + 6'h01) begin
            k = WR_SET;
        end else if (a == base + 6'h02) begin
            k = WR_CLEAR;
        end
        return k;
    endfunction : wr_kind

    // ---------------------------------------------
    // Decode
    // ---------------------------------------------
    logic [7:0] tx_amp_r;
    logic [7:0] headset_r;
    logic [7:0] rid_r;
    logic [7:0] rid_nxt;
    logic [7:0] io_r;
    logic [2:0] adc_meta_r;
    logic [2:0] adc_sync_r;
    logic [CW-1:0] conv_cnt_r;
    upv_conv_state_type conv_state_r;
    logic latch_r;
    logic alt_int_r;
    logic sel_vendor;
    logic sel_rid;
    logic sel_io;
    logic conv_finish;
    logic irq_en_eff;
    logic start_rise;

    // Vendor window and triple-address groups
    assign sel_vendor = (i_reg_addr >= ADDR_VENDOR_LO) && (i_reg_addr <= ADDR_VENDOR_HI);
    assign sel_rid = (i_reg_addr >= ADDR_RID_WR) && (i_reg_addr <= ADDR_RID_CLR);
    assign sel_io = (i_reg_addr >= ADDR_IO_WR) && (i_reg_addr <= ADDR_IO_CLR);
    assign o_reg_hit = sel_vendor;
    assign conv_finish = (conv_state_r == CONV_BUSY) && (conv_cnt_r == CONV_LAST);
    assign irq_en_eff = rid_r[RID_IRQ_EN_BIT] | i_carkit_irq_enable;
    assign o_id_conversion_active = (conv_state_r == CONV_BUSY);

    // ---------------------------------------------
    // Plain registers
    // ---------------------------------------------
    // Amplitude and headset registers
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            tx_amp_r <= TX_AMP_RESET;
            headset_r <= HEADSET_RESET;
        end else if (i_reg_wr) begin
            if (i_reg_addr == ADDR_TX_AMP) begin
                tx_amp_r <= i_reg_wdata & TX_AMP_MASK;
            end
            if (i_reg_addr == ADDR_HEADSET) begin
                headset_r <= i_reg_wdata & HEADSET_MASK;
            end
        end
    end

    // I/O and power register, bit 0 stays zero
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            io_r <= IO_RESET;
        end else if (i_reg_wr && sel_io) begin
            io_r <= apply_wr(io_r, i_reg_wdata, wr_kind(i_reg_addr, ADDR_IO_WR),
                             IO_MASK);
        end
    end

    // ---------------------------------------------
    // Conversion register
    // ---------------------------------------------
    // Converter result synchroniser
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            adc_meta_r <= 3'h0;
            adc_sync_r <= 3'h0;
        end else begin
            adc_meta_r <= i_id_adc_code;
            adc_sync_r <= adc_meta_r;
        end
    end

    // Next value: host access, then done clear, then completion
    always_comb begin
        rid_nxt = rid_r;
        if (i_reg_wr && sel_rid) begin
            rid_nxt = apply_wr(rid_r, i_reg_wdata, wr_kind(i_reg_addr, ADDR_RID_WR),
                               RID_WRITE_MASK) | (rid_r & ~RID_WRITE_MASK);
        end
        if (i_reg_rd && sel_rid) begin
            rid_nxt[RID_DONE_BIT] = 1'b0;
        end
        if (conv_finish) begin
            rid_nxt[RID_VALUE_LSB +: 3] = adc_sync_r;
            rid_nxt[RID_DONE_BIT] = 1'b1;
            rid_nxt[RID_START_BIT] = 1'b0;
        end
    end

    // Conversion register storage
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            rid_r <= RID_RESET;
        end else begin
            rid_r <= rid_nxt & RID_MASK;
        end
    end

    // Start bit going high launches a conversion
    assign start_rise = rid_nxt[RID_START_BIT] && !rid_r[RID_START_BIT];

    // Conversion timer
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            conv_state_r <= CONV_IDLE;
            conv_cnt_r <= '0;
        end else begin
            case (conv_state_r)
                CONV_IDLE: begin
                    conv_cnt_r <= '0;
                    if (start_rise) begin
                        conv_state_r <= CONV_BUSY;
                    end
                end
                CONV_BUSY: begin
                    if (conv_finish) begin
                        conv_state_r <= CONV_IDLE;
                        conv_cnt_r <= '0;
                    end else begin
                        conv_cnt_r <= conv_cnt_r + CW'(1);
                    end
                end
                default: begin
                    conv_state_r <= CONV_IDLE;
                    conv_cnt_r <= '0;
                end
            endcase
        end
    end

    // ---------------------------------------------
    // Event latch and interrupt
    // ---------------------------------------------
    // Latch sets on done rise with enable, set beats read
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            latch_r <= 1'b0;
            alt_int_r <= 1'b0;
        end else begin
            alt_int_r <= conv_finish && !rid_r[RID_DONE_BIT] && irq_en_eff;
            if (conv_finish && !rid_r[RID_DONE_BIT] && irq_en_eff) begin
                latch_r <= 1'b1;
            end else if (i_carkit_latch_rd) begin
                latch_r <= 1'b0;
            end
        end
    end

    assign o_alt_int = alt_int_r;

    // ---------------------------------------------
    // Read data and outputs
    // ---------------------------------------------
    // Registered read data, unmapped reads zero
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            o_reg_rdata <= 8'h00;
        end else if (i_reg_rd) begin
            if (i_reg_addr == ADDR_TX_AMP) begin
                o_reg_rdata <= tx_amp_r;
            end else if (i_reg_addr == ADDR_HEADSET) begin
                o_reg_rdata <= headset_r;
            end else if (sel_rid) begin
                o_reg_rdata <= rid_r;
            end else if (sel_io) begin
                o_reg_rdata <= io_r;
            end else begin
                o_reg_rdata <= 8'h00;
            end
        end
    end

    // Carkit view of value, done and latch; its status read clears nothing, its latch read clears the latch
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            o_carkit_view <= '0;
        end else begin
            o_carkit_view.id_resistance_code <= rid_r[RID_VALUE_LSB +: 3];
            o_carkit_view.id_conversion_done <= rid_r[RID_DONE_BIT];
            o_carkit_view.id_conversion_event_latch <= latch_r;
        end
    end

    // PHY control outputs
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            o_phy_ctrl <= '0;
        end else begin
            o_phy_ctrl.tx_amplitude <= tx_amp_r[TX_AMP_LSB +: 2];
            o_phy_ctrl.headset_audio_enable <= (headset_r[3:0] == HEADSET_ENABLE_CODE);
            o_phy_ctrl.data_line_swap <= io_r[IO_SWAP_BIT];
            o_phy_ctrl.charger_pullup_positive_line <= io_r[IO_PULLUP_POS_BIT]
                | i_serial_mode;
            o_phy_ctrl.charger_pullup_negative_line <= io_r[IO_PULLUP_NEG_BIT]
                | i_serial_mode;
            if (i_serial_mode && i_serial_transmit_enable) begin
                o_phy_ctrl.regulator_select <= io_r[IO_SERIAL_REG_LSB +: 2];
            end else begin
                o_phy_ctrl.regulator_select <= io_r[IO_USB_REG_LSB +: 2];
            end
        end
    end

    // ---------------------------------------------
    // Assertions
    // ---------------------------------------------
    sequence seq_conv_end;
        conv_state_r == CONV_BUSY && conv_cnt_r == CONV_LAST;
    endsequence

    sequence seq_done_set;
        rid_r[RID_DONE_BIT] && !rid_r[RID_START_BIT] && conv_state_r == CONV_IDLE;
    endsequence

    a_conv_done_end: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        seq_conv_end |=> seq_done_set)
        else $error("done or start wrong after conversion");

    a_conv_start_go: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        (conv_state_r == CONV_IDLE && start_rise) |=> conv_state_r == CONV_BUSY && conv_cnt_r == 0)
        else $error("conversion did not start");

    a_conv_count_step: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        (conv_state_r == CONV_BUSY && conv_cnt_r != CONV_LAST)
        |=> conv_state_r == CONV_BUSY && conv_cnt_r == $past(conv_cnt_r) + CW'(1))
        else $error("conversion timer skipped");

    a_read_clears_done: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        (i_reg_rd && sel_rid && !conv_finish) |=> !rid_r[RID_DONE_BIT])
        else $error("done not cleared by read");

    a_finish_beats_read: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        (conv_finish && i_reg_rd && sel_rid) |=> rid_r[RID_DONE_BIT])
        else $error("done lost to read");

    a_carkit_keeps_done: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        (rid_r[RID_DONE_BIT] && i_carkit_status_rd && !(i_reg_rd && sel_rid))
        |=> rid_r[RID_DONE_BIT])
        else $error("carkit read cleared done");

    a_irq_latch_pair: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        (seq_conv_end and (!rid_r[RID_DONE_BIT] && irq_en_eff))
        |=> o_alt_int && latch_r ##1 !o_alt_int)
        else $error("interrupt or latch missing");

    a_no_irq_disabled: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        (!rid_r[RID_IRQ_EN_BIT] && !i_carkit_irq_enable) |=> !o_alt_int)
        else $error("interrupt while disabled");

    a_set_or_bits: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        (i_reg_wr && i_reg_addr == ADDR_IO_SET)
        |=> io_r == (($past(io_r) | $past(i_reg_wdata)) & IO_MASK))
        else $error("set access wrong");

    a_clr_bits: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        (i_reg_wr && i_reg_addr == ADDR_IO_CLR) |=> io_r == ($past(io_r) & ~$past(i_reg_wdata)))
        else $error("clear access wrong");

    a_headset_code: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        ##1 o_phy_ctrl.headset_audio_enable == ($past(headset_r[3:0]) == 4'hA))
        else $error("headset enable mismatch");

    a_regulator_pick: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        (i_serial_mode && i_serial_transmit_enable)
        |=> o_phy_ctrl.regulator_select == $past(io_r[3:2]))
        else $error("serial regulator select wrong");

    a_serial_pullups: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        i_serial_mode
        |=> o_phy_ctrl.charger_pullup_positive_line && o_phy_ctrl.charger_pullup_negative_line)
        else $error("pull-ups not forced in serial mode");

    a_latch_read_clr: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        (i_carkit_latch_rd && !(conv_finish && !rid_r[RID_DONE_BIT] && irq_en_eff))
        |=> !latch_r)
        else $error("latch not cleared by read");

    a_swap_follow: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        1'b1 |=> o_phy_ctrl.data_line_swap == $past(io_r[IO_SWAP_BIT]))
        else $error("line swap not applied");

    a_amp_follow: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        1'b1 |=> o_phy_ctrl.tx_amplitude == $past(tx_amp_r[TX_AMP_LSB +: 2]))
        else $error("amplitude not applied");

    a_rid_load: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        (i_reg_wr && i_reg_addr == ADDR_RID_WR && !conv_finish)
        |=> rid_r[RID_VALUE_LSB +: 3] == $past(i_reg_wdata[RID_VALUE_LSB +: 3]))
        else $error("conversion register load wrong");

endmodule : upv_vendor_regs

// >>> verif/upv_link_model.sv
`timescale 1ns/1ps
module upv_link_model (
    // Clock
    input wire logic i_clk_sys,
    // Register port toward the device
    output logic o_reg_wr,
    output logic o_reg_rd,
    output logic [5:0] o_reg_addr,
    output logic [7:0] o_reg_wdata,
    input wire logic [7:0] i_reg_rdata
);
    // Idle port at time zero
    initial begin
        o_reg_wr = 1'b0;
        o_reg_rd = 1'b0;
        o_reg_addr = 6'h00;
        o_reg_wdata = 8'h00;
    end

    // One-cycle write strobe; bit 5 of the conversion register kept low
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(negedge i_clk_sys);
        o_reg_addr = a;
        o_reg_wdata = (a >= 6'h36 && a <= 6'h38) ? (d & 8'hDF) : d;
        o_reg_wr = 1'b1;
        @(negedge i_clk_sys);
        o_reg_wr = 1'b0;
        o_reg_wdata = ~o_reg_wdata; // Released data no longer valid
    endtask : wr

    // One-cycle read strobe, data taken once settled
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(negedge i_clk_sys);
        o_reg_addr = a;
        o_reg_rd = 1'b1;
        @(negedge i_clk_sys);
        o_reg_rd = 1'b0;
        @(negedge i_clk_sys);
        d = i_reg_rdata;
    endtask : rd
endmodule : upv_link_model

// >>> verif/test_ulpi_phy_vendor_register_bank.sv
`timescale 1ns/1ps
module test_ulpi_phy_vendor_register_bank;
    import upv_pkg::*;
    localparam int P = 20;
    logic i_clk_sys = 1'b0;
    logic i_resetn = 1'b0;
    logic reg_wr, reg_rd, hit, alt, active;
    logic [5:0] addr;
    logic [7:0] wdata, rdata, v;
    logic ck_en = 1'b0, ck_st = 1'b0, ck_lt = 1'b0, ser = 1'b0, txen = 1'b0;
    logic [2:0] adc = 3'h0;
    upv_carkit_view_type view;
    upv_phy_ctrl_type phy;
    int errors = 0;
    int check_count = 0;
    int n;

    // Clock at 250 MHz
    always #2 i_clk_sys = ~i_clk_sys;

    upv_vendor_regs #(.P_CONV_CYCLES(P)) dut (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
        .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .i_reg_addr(addr), .i_reg_wdata(wdata),
        .o_reg_rdata(rdata), .o_reg_hit(hit), .i_carkit_irq_enable(ck_en),
        .i_carkit_status_rd(ck_st), .i_carkit_latch_rd(ck_lt), .o_carkit_view(view),
        .i_id_adc_code(adc), .i_serial_mode(ser), .i_serial_transmit_enable(txen),
        .o_id_conversion_active(active), .o_phy_ctrl(phy), .o_alt_int(alt));

    upv_link_model link (.i_clk_sys(i_clk_sys), .o_reg_wr(reg_wr), .o_reg_rd(reg_rd),
        .o_reg_addr(addr), .o_reg_wdata(wdata), .i_reg_rdata(rdata));

    // ---------------------------------------------
    // Shared helpers
    // ---------------------------------------------
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Read a register and compare
    task automatic rc(input logic [5:0] a, input logic [7:0] exp);
        link.rd(a, v);
        check($sformatf("reg %h", a), v, exp);
    endtask : rc

    // Count falling edges until the interrupt pulse, bounded
    task automatic wait_alt(output int k);
        k = 0;
        while (k < 4 * P) begin
            @(negedge i_clk_sys);
            k++;
            if (alt === 1'b1) break;
        end
    endtask : wait_alt

    task automatic print_verdict;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : print_verdict

    // ---------------------------------------------
    // Scenarios
    // ---------------------------------------------
    task automatic t_reset;
        rc(6'h31, 8'h00);
        rc(6'h33, 8'h00);
        rc(6'h36, 8'h00);
        rc(6'h39, 8'h04);
        check("phy", phy, 8'h00);
        $display("reset values done");
    endtask : t_reset

    task automatic t_amp_headset;
        link.wr(6'h31, 8'hFF);
        rc(6'h31, 8'h60);
        check("amp", 8'(phy.tx_amplitude), 8'h03);
        link.wr(6'h31, 8'h40);
        rc(6'h31, 8'h40);
        check("amp", 8'(phy.tx_amplitude), 8'h02);
        for (int k = 0; k < 16; k++) begin
            link.wr(6'h33, {4'hF, k[3:0]});
            rc(6'h33, {4'h0, k[3:0]});
            check("headset", 8'(phy.headset_audio_enable), {7'h0, k == 10});
        end
        $display("amplitude and headset done");
    endtask : t_amp_headset

    task automatic t_io;
        link.wr(6'h39, 8'h00);
        rc(6'h39, 8'h00);
        link.wr(6'h3A, 8'h10);
        rc(6'h3A, 8'h10);
        check("pull pos", 8'(phy.charger_pullup_positive_line), 8'h01);
        link.wr(6'h3A, 8'h22);
        rc(6'h3B, 8'h32);
        check("swap", 8'(phy.data_line_swap), 8'h01);
        check("pull neg", 8'(phy.charger_pullup_negative_line), 8'h01);
        link.wr(6'h3B, 8'h12);
        rc(6'h39, 8'h20);
        link.wr(6'h39, 8'hFF);
        rc(6'h39, 8'hFE);
        check("reg sel", 8'(phy.regulator_select), 8'h03);
        link.wr(6'h39, 8'h48);
        rc(6'h39, 8'h48);
        ser = 1'b1;
        repeat (2) @(negedge i_clk_sys);
        check("reg sel", 8'(phy.regulator_select), 8'h01);
        txen = 1'b1;
        repeat (2) @(negedge i_clk_sys);
        check("reg sel", 8'(phy.regulator_select), 8'h02);
        check("pulls pos", 8'(phy.charger_pullup_positive_line), 8'h01);
        check("pulls neg", 8'(phy.charger_pullup_negative_line), 8'h01);
        ser = 1'b0;
        txen = 1'b0;
        repeat (2) @(negedge i_clk_sys);
        check("pull pos", 8'(phy.charger_pullup_positive_line), 8'h00);
        $display("io and power done");
    endtask : t_io

    task automatic t_decode;
        link.rd(6'h2F, v);
        check("hit", 8'(hit), 8'h00);
        link.rd(6'h30, v);
        check("hit", 8'(hit), 8'h01);
        rc(6'h3F, 8'h00);
        check("hit", 8'(hit), 8'h01);
        link.wr(6'h32, 8'hFF);
        rc(6'h32, 8'h00);
        $display("decode done");
    endtask : t_decode

    task automatic t_conv;
        adc = 3'h5;
        link.wr(6'h36, 8'h50);
        @(negedge i_clk_sys);
        check("active", 8'(active), 8'h01);
        // Write edge to pulse is P cycles; two falling edges already gone
        wait_alt(n);
        check("latency", n[7:0], 8'(P - 1));
        check("active", 8'(active), 8'h00);
        // Carkit view trails the register by one cycle
        @(negedge i_clk_sys);
        check("view", {3'h0, view}, {3'h0, 3'h5, 1'b1, 1'b1});
        ck_st = 1'b1;
        @(negedge i_clk_sys);
        ck_st = 1'b0;
        repeat (2) @(negedge i_clk_sys);
        check("done", 8'(view.id_conversion_done), 8'h01);
        rc(6'h38, 8'h4D);
        rc(6'h36, 8'h45);
        link.wr(6'h38, 8'h40);
        rc(6'h36, 8'h05);
        ck_lt = 1'b1;
        @(negedge i_clk_sys);
        ck_lt = 1'b0;
        repeat (2) @(negedge i_clk_sys);
        check("latch", 8'(view.id_conversion_event_latch), 8'h00);
        $display("conversion done");
    endtask : t_conv

    task automatic t_irq_enable;
        link.wr(6'h36, 8'h00);
        ck_en = 1'b1;
        adc = 3'h3;
        link.wr(6'h37, 8'h10);
        // Pulse lands P cycles after the set edge
        wait_alt(n);
        check("carkit en", n[7:0], 8'(P));
        ck_en = 1'b0;
        rc(6'h37, 8'h0B);
        link.wr(6'h37, 8'h10);
        wait_alt(n);
        check("no irq", n[7:0], 8'(4 * P));
        rc(6'h36, 8'h0B);
        $display("interrupt enable done");
    endtask : t_irq_enable

    // Main sequence
    initial begin
        repeat (8) @(posedge i_clk_sys);
        @(negedge i_clk_sys);
        i_resetn = 1'b1;
        t_reset();
        t_amp_headset();
        t_io();
        t_decode();
        t_conv();
        t_irq_enable();
        print_verdict();
    end

    // Watchdog
    initial begin
        #50000;
        errors++;
        print_verdict();
    end
endmodule : test_ulpi_phy_vendor_register_bank
